// ==== pkg/slot_regs_map.svh ====
/*
  Constants of the chassis controller serial registers: field positions,
  widths, slot numbers, reset values.
  Assumes inclusion by the package and by each design file that needs it.
*/
// Overview of operation
// - A 16-bit write-only slot-select word picks the module talked to afterwards.
// - While select is low, serial data shifts into slot-select, MSB first.
// - With select high, only the module at the held slot and chassis is enabled.
// - Chassis number sits in bits 8..4, slot in bits 3..0; 15..9 ignored.
// - Single-chassis setup ignores the chassis field entirely.
// - Every chassis captures each slot-select write at the same moment.
// - Chassis identity comes from static jumpers; only a matching chassis responds.
// - Control register and scan list are per chassis, written only when selected.
// - Slot 13 reaches the control register, slot 14 the scan-list FIFO.
// - The hardscan control register is 8 bits, write-only, setting scan timing.
// - With slot 13 selected, data shifts into the control register, bit 7 first.
// - A 16-bit write-only FIFO register feeds the chassis scan list.
// - Control bit 4 set halts scanning at list end; clear wraps to entry one.
// - With slot 14 selected, data shifts into the FIFO; each write appends one entry.
// - The scan list holds at most 256 entries.
// - Entry bits 10..7 give slot minus one, bits 6..0 sample count minus one.
// - Writing the scan reset bit as zero resets scanning and empties the FIFO.
`ifndef SLOT_REGS_MAP_SVH
`define SLOT_REGS_MAP_SVH
// Word lengths in link clock edges
`define SEL_WORD_BITS 5'h10
`define HARDSCAN_CONTROL_WORD_BITS 5'h08
`define FIFO_WORD_BITS 5'h10
// Slot-select fields
`define CHS_MSB 8
`define CHS_LSB 4
`define SL_MSB 3
`define SL_LSB 0
// Internal slot numbers
`define HARDSCAN_CONTROL_SLOT 4'hd
`define FIFO_SLOT 4'he
// Hardscan control bits
`define HARDSCAN_CONTROL_FRT 6
`define HARDSCAN_CONTROL_ONCE 4
`define HARDSCAN_CONTROL_RESET_N 3
`define HARDSCAN_CONTROL_SCANCON 1
`define HARDSCAN_CONTROL_TRIGGER_CLOCK_ENABLE 0
// Scan list entry fields
`define MOD_MSB 10
`define MOD_LSB 7
`define CNT_MSB 6
`define CNT_LSB 0
`define FIFO_DEPTH 9'h100
// Reset values
`define SEL_RESET 16'h0000
`define HARDSCAN_CONTROL_RESET 8'h00
`endif

// ==== pkg/slot_regs_pkg.sv ====
/*
  Types and shared decode functions of the chassis controller registers.
  Assumes slot_regs_map.svh is on the include path.
*/
package slot_regs_pkg;
  `include "slot_regs_map.svh"

  // Kind of completed serial word
  typedef enum logic [1:0] {
    XFER_NONE = 2'h0,
    XFER_SEL = 2'h1,
    XFER_HARDSCAN_CONTROL = 2'h3,
    XFER_FIFO = 2'h2
  } xfer_kind_t;

  // Word handed from the link domain
  typedef struct packed {
    xfer_kind_t kind;
    logic [15:0] word;
  } xfer_t;

  // One scan list entry
  typedef struct packed {
    logic [3:0] module_field;
    logic [6:0] count;
  } scan_entry_t;

  // Scan sequencer states, Gray along idle, run, halt
  typedef enum logic [1:0] {
    SCAN_IDLE = 2'h0,
    SCAN_RUN = 2'h1,
    SCAN_HALT = 2'h3
  } scan_state_t;

  // True when this chassis is addressed by the slot-select word
  function automatic logic chassis_hit(input logic [15:0] word, input logic [4:0] id,
                                       input logic single);
    return single | (word[`CHS_MSB:`CHS_LSB] == id);
  endfunction : chassis_hit

  // Slot number field of the slot-select word
  function automatic logic [3:0] slot_of(input logic [15:0] word);
    return word[`SL_MSB:`SL_LSB];
  endfunction : slot_of
endpackage : slot_regs_pkg

// ==== core/link_shifter.sv ====
/*
  Serial shifter on the link clock: assembles slot-select, control and
  scan list words and hands each completed word over with a toggle.
  Assumes MOSI and the select line change with the link clock.
*/
`timescale 1ns/10ps
`include "slot_regs_map.svh"
module link_shifter
  import slot_regs_pkg::*;
(
  // Link
  input wire logic link_clk,
  input wire logic link_rst,
  input wire logic mosi,
  input wire logic select_n,
  // Static strapping
  input wire logic [4:0] chassis_id,
  input wire logic single_chassis,
  // Handoff to system domain
  output xfer_t xfer_q,
  output logic xfer_tgl_q
);
  logic low_run_q;
  logic high_run_q;
  logic [4:0] cnt_q;
  logic [15:0] shift_q;
  logic [15:0] sel_word_q;
  logic [4:0] id_meta_q;
  logic [4:0] id_q;
  logic single_meta_q;
  logic single_q;
  logic [4:0] base;
  logic [4:0] need;
  xfer_kind_t kind;
  logic done;

  // Jumper inputs pass two flops
  always_ff @(posedge link_clk or posedge link_rst)
    if (link_rst)
    begin
      id_meta_q <= 5'h00;
      id_q <= 5'h00;
      single_meta_q <= 1'b0;
      single_q <= 1'b0;
    end
    else
    begin
      id_meta_q <= chassis_id;
      id_q <= id_meta_q;
      single_meta_q <= single_chassis;
      single_q <= single_meta_q;
    end

  // Low-frame marker: cleared at once when select rises, so a new frame restarts
  // its bit count even if the link clock stood still while select was high
  always_ff @(posedge link_clk or posedge link_rst or posedge select_n)
    if (link_rst || select_n)
      low_run_q <= 1'b0;
    else
      low_run_q <= 1'b1;

  // High-frame marker: cleared at once when select falls
  always_ff @(posedge link_clk or posedge link_rst or negedge select_n)
    if (link_rst || !select_n)
      high_run_q <= 1'b0;
    else
      high_run_q <= 1'b1;

  // Target of this edge's bit and word completion
  always_comb
  begin
    base = (select_n ? high_run_q : low_run_q) ? cnt_q : 5'h00;
    kind = XFER_NONE;
    need = `SEL_WORD_BITS;
    if (!select_n)
      kind = XFER_SEL;
    else if (chassis_hit(sel_word_q, id_q, single_q))
    begin
      if (slot_of(sel_word_q) == `HARDSCAN_CONTROL_SLOT)
      begin
        kind = XFER_HARDSCAN_CONTROL;
        need = `HARDSCAN_CONTROL_WORD_BITS;
      end
      else if (slot_of(sel_word_q) == `FIFO_SLOT)
      begin
        kind = XFER_FIFO;
        need = `FIFO_WORD_BITS;
      end
    end
    done = (kind != XFER_NONE) && (base + 5'h01 == need);
  end

  // Shift register, MSB first, bit counter restarts on select change
  always_ff @(posedge link_clk or posedge link_rst)
    if (link_rst)
    begin
      cnt_q <= 5'h00;
      shift_q <= 16'h0000;
    end
    else
    begin
      if (kind != XFER_NONE)
      begin
        shift_q <= {shift_q[14:0], mosi};
        cnt_q <= done ? 5'h00 : base + 5'h01;
      end
      else
        cnt_q <= 5'h00;
    end

  // Committed words; slot-select taken by every chassis alike
  always_ff @(posedge link_clk or posedge link_rst)
    if (link_rst)
    begin
      sel_word_q <= `SEL_RESET;
      xfer_q <= '0;
      xfer_tgl_q <= 1'b0;
    end
    else if (done)
    begin
      xfer_q.kind <= kind;
      xfer_q.word <= {shift_q[14:0], mosi};
      xfer_tgl_q <= ~xfer_tgl_q;
      if (kind == XFER_SEL)
        sel_word_q <= {shift_q[14:0], mosi};
    end

  a_sel_whole: assert property (@(posedge link_clk) disable iff (link_rst)
    cnt_q != 5'h0f || select_n |=> $stable(sel_word_q))
    else $error("Slot-select changed without a full word");
endmodule : link_shifter

// ==== core/scan_list_store.sv ====
/*
  Scan list storage: up to 256 entries appended in order, read by index.
  Assumes push and clear come from logic on the same clock.
*/
`timescale 1ns/10ps
`include "slot_regs_map.svh"
module scan_list_store
  import slot_regs_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic clear,
  // Append side
  input wire logic push,
  input scan_entry_t push_entry,
  // Read side
  input wire logic [7:0] rd_idx,
  output scan_entry_t rd_entry,
  output logic [8:0] fill_q
);
  scan_entry_t mem_q [0:255];
  logic full;

  assign full = (fill_q == `FIFO_DEPTH);
  assign rd_entry = mem_q[rd_idx];

  // Entry write at the end of the list
  always_ff @(posedge clk)
    if (push && !full && !clear)
      mem_q[fill_q[7:0]] <= push_entry;

  // Fill count, emptied by clear; pushes beyond depth dropped
  always_ff @(posedge clk or posedge rst)
    if (rst)
      fill_q <= 9'h000;
    else if (clear)
      fill_q <= 9'h000;
    else if (push && !full)
      fill_q <= fill_q + 9'h001;

  a_clear_empties: assert property (@(posedge clk) disable iff (rst)
    clear |=> fill_q == 9'h000)
    else $error("Clear did not empty the scan list");
  a_full_holds: assert property (@(posedge clk) disable iff (rst)
    full && !clear |=> fill_q == `FIFO_DEPTH)
    else $error("Scan list grew beyond its depth");
endmodule : scan_list_store

// ==== core/chassis_slot_select_serial_regs.sv ====
/*
  Chassis controller serial register set: slot-select word, hardscan
  control register, scan-list FIFO and the scan sequencer it feeds.
  Assumes the acquisition board drives LINK_SCLK, MOSI and the select
  line; SAMPLE_TICK is a one-cycle pulse from timing logic on CLOCK.
*/
`timescale 1ns/10ps
`include "slot_regs_map.svh"
module chassis_slot_select_serial_regs
  import slot_regs_pkg::*;
(
  // System clock and reset
  input wire logic CLOCK,
  input wire logic SYS_RST,
  // Serial link from the acquisition board
  input wire logic LINK_SCLK,
  input wire logic MOSI,
  input wire logic CONTROLLER_SELECT_N,
  // Chassis jumpers
  input wire logic [4:0] CHASSIS_ID,
  input wire logic SINGLE_CHASSIS,
  // Scan timing
  input wire logic SAMPLE_TICK,
  // Module slot enables
  output logic [15:0] SLOT_ENABLE,
  // Hardscan control outputs
  output logic SCAN_CONTROL_ENABLE,
  output logic TRIGGER_CLOCK_ENABLE,
  output logic SCAN_LIST_REWIND,
  output logic SCAN_LOGIC_RESET_N,
  // Scan sequencer
  output logic [3:0] SCAN_SLOT,
  output logic SCAN_ACTIVE,
  output logic SCAN_DONE
);
  // ------------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------------
  xfer_t xfer;
  logic xfer_tgl;
  logic tgl_meta_q;
  logic tgl_sync_q;
  logic tgl_prev_q;
  logic load;
  logic sel_meta_q;
  logic sel_sync_q;
  logic [4:0] id_meta_q;
  logic [4:0] id_q;
  logic single_meta_q;
  logic single_q;
  logic [15:0] slot_word_q;
  logic [7:0] hardscan_control_q;
  logic sel_high;
  logic hit;
  logic [3:0] slot;
  logic push;
  scan_entry_t push_entry;
  scan_entry_t rd_entry;
  logic [8:0] fill;
  logic scan_clear;
  scan_state_t state_q;
  scan_state_t state_d;
  logic [7:0] idx_q;
  logic [7:0] idx_d;
  logic [7:0] nxt_idx;
  logic [6:0] remain_q;
  logic [6:0] remain_d;
  logic [3:0] slot_d;
  logic last;

  // ------------------------------------------------------------------
  // Link domain
  // ------------------------------------------------------------------
  // Serial assembly runs on the link clock
  link_shifter u_shifter (
    .link_clk(LINK_SCLK),
    .link_rst(SYS_RST),
    .mosi(MOSI),
    .select_n(CONTROLLER_SELECT_N),
    .chassis_id(CHASSIS_ID),
    .single_chassis(SINGLE_CHASSIS),
    .xfer_q(xfer),
    .xfer_tgl_q(xfer_tgl)
  );

  // ------------------------------------------------------------------
  // Crossing into the system domain
  // ------------------------------------------------------------------
  // Word toggle: two flops, then an edge detect on the second
  always_ff @(posedge CLOCK or posedge SYS_RST)
    if (SYS_RST)
    begin
      tgl_meta_q <= 1'b0;
      tgl_sync_q <= 1'b0;
      tgl_prev_q <= 1'b0;
    end
    else
    begin
      tgl_meta_q <= xfer_tgl;
      tgl_sync_q <= tgl_meta_q;
      tgl_prev_q <= tgl_sync_q;
    end

  // Word held stable by the link side until the next toggle
  assign load = tgl_sync_q ^ tgl_prev_q;

  // Select line and jumpers pass two flops
  always_ff @(posedge CLOCK or posedge SYS_RST)
    if (SYS_RST)
    begin
      sel_meta_q <= 1'b0;
      sel_sync_q <= 1'b0;
      id_meta_q <= 5'h00;
      id_q <= 5'h00;
      single_meta_q <= 1'b0;
      single_q <= 1'b0;
    end
    else
    begin
      sel_meta_q <= CONTROLLER_SELECT_N;
      sel_sync_q <= sel_meta_q;
      id_meta_q <= CHASSIS_ID;
      id_q <= id_meta_q;
      single_meta_q <= SINGLE_CHASSIS;
      single_q <= single_meta_q;
    end

  // ------------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------------
  // Slot-select copy; only whole words arrive here
  always_ff @(posedge CLOCK or posedge SYS_RST)
    if (SYS_RST)
      slot_word_q <= `SEL_RESET;
    else if (load && xfer.kind == XFER_SEL)
      slot_word_q <= xfer.word;

  // Hardscan control register, low byte of the shifted word
  always_ff @(posedge CLOCK or posedge SYS_RST)
    if (SYS_RST)
      hardscan_control_q <= `HARDSCAN_CONTROL_RESET;
    else if (load && xfer.kind == XFER_HARDSCAN_CONTROL)
      hardscan_control_q <= xfer.word[7:0];

  // Control bits straight from the register
  assign SCAN_CONTROL_ENABLE = hardscan_control_q[`HARDSCAN_CONTROL_SCANCON];
  assign TRIGGER_CLOCK_ENABLE = hardscan_control_q[`HARDSCAN_CONTROL_TRIGGER_CLOCK_ENABLE];
  assign SCAN_LIST_REWIND = hardscan_control_q[`HARDSCAN_CONTROL_FRT];
  assign SCAN_LOGIC_RESET_N = hardscan_control_q[`HARDSCAN_CONTROL_RESET_N];

  // Scan logic held in reset while the reset bit reads zero
  assign scan_clear = !hardscan_control_q[`HARDSCAN_CONTROL_RESET_N];

  // ------------------------------------------------------------------
  // Slot enables
  // ------------------------------------------------------------------
  // Decode of the held word against this chassis
  assign sel_high = sel_sync_q;
  assign hit = chassis_hit(slot_word_q, id_q, single_q);
  assign slot = slot_of(slot_word_q);

  // One module enabled while select is high; slots 13 and 14 stay inside
  always_ff @(posedge CLOCK or posedge SYS_RST)
    if (SYS_RST)
      SLOT_ENABLE <= 16'h0000;
    else if (sel_high && hit && slot != `HARDSCAN_CONTROL_SLOT && slot != `FIFO_SLOT)
      SLOT_ENABLE <= 16'h0001 << slot;
    else
      SLOT_ENABLE <= 16'h0000;

  // ------------------------------------------------------------------
  // Scan list
  // ------------------------------------------------------------------
  // Entry fields of a completed FIFO word
  assign push = load && (xfer.kind == XFER_FIFO);
  assign push_entry.module_field = xfer.word[`MOD_MSB:`MOD_LSB];
  assign push_entry.count = xfer.word[`CNT_MSB:`CNT_LSB];

  scan_list_store u_store (
    .clk(CLOCK),
    .rst(SYS_RST),
    .clear(scan_clear),
    .push(push),
    .push_entry(push_entry),
    .rd_idx(nxt_idx),
    .rd_entry(rd_entry),
    .fill_q(fill)
  );

  // ------------------------------------------------------------------
  // Scan sequencer
  // ------------------------------------------------------------------
  // Index of the entry to load next
  always_comb
  begin
    last = ({1'b0, idx_q} + 9'h001 == fill);
    nxt_idx = (state_q == SCAN_RUN && !last) ? idx_q + 8'h01 : 8'h00;
  end

  // Next state; each entry lasts count plus one sample ticks
  always_comb
  begin
    state_d = state_q;
    idx_d = idx_q;
    remain_d = remain_q;
    slot_d = SCAN_SLOT;
    case (state_q)
      SCAN_IDLE:
        if (SAMPLE_TICK && fill != 9'h000)
        begin
          state_d = SCAN_RUN;
          idx_d = 8'h00;
          remain_d = rd_entry.count;
          slot_d = rd_entry.module_field + 4'h1;
        end
      SCAN_RUN:
        if (SAMPLE_TICK)
        begin
          if (remain_q != 7'h00)
            remain_d = remain_q - 7'h01;
          else if (last && hardscan_control_q[`HARDSCAN_CONTROL_ONCE])
            state_d = SCAN_HALT;
          else
          begin
            idx_d = nxt_idx;
            remain_d = rd_entry.count;
            slot_d = rd_entry.module_field + 4'h1;
          end
        end
      SCAN_HALT:
        state_d = SCAN_HALT;
      default:
        state_d = SCAN_IDLE;
    endcase
  end

  // Sequencer registers; clear returns to idle
  always_ff @(posedge CLOCK or posedge SYS_RST)
    if (SYS_RST)
    begin
      state_q <= SCAN_IDLE;
      idx_q <= 8'h00;
      remain_q <= 7'h00;
      SCAN_SLOT <= 4'h0;
      SCAN_ACTIVE <= 1'b0;
      SCAN_DONE <= 1'b0;
    end
    else if (scan_clear)
    begin
      state_q <= SCAN_IDLE;
      idx_q <= 8'h00;
      remain_q <= 7'h00;
      SCAN_SLOT <= 4'h0;
      SCAN_ACTIVE <= 1'b0;
      SCAN_DONE <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      idx_q <= idx_d;
      remain_q <= remain_d;
      SCAN_SLOT <= slot_d;
      SCAN_ACTIVE <= (state_d == SCAN_RUN);
      SCAN_DONE <= (state_d == SCAN_HALT);
    end

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  a_sel_load: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    load && xfer.kind == XFER_SEL |=> slot_word_q == $past(xfer.word))
    else $error("Slot-select word not loaded");
  a_hardscan_control_load: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    load && xfer.kind == XFER_HARDSCAN_CONTROL |=> hardscan_control_q == $past(xfer.word[7:0]))
    else $error("Control register not loaded");
  a_enable_onehot: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    $onehot0(SLOT_ENABLE))
    else $error("More than one slot enabled");
  a_enable_cause: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    SLOT_ENABLE != 16'h0000 |-> $past(sel_high) && $past(hit))
    else $error("Slot enabled without select or chassis match");
  a_internal_slots: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    !SLOT_ENABLE[`HARDSCAN_CONTROL_SLOT] && !SLOT_ENABLE[`FIFO_SLOT])
    else $error("Internal slot driven as a module enable");
  a_fifo_push: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    load && xfer.kind == XFER_FIFO && !scan_clear && fill != `FIFO_DEPTH
    |=> fill == $past(fill) + 9'h001)
    else $error("FIFO word not appended");
  a_once_halt: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    state_q == SCAN_RUN && SAMPLE_TICK && remain_q == 7'h00 && last
    && hardscan_control_q[`HARDSCAN_CONTROL_ONCE] && !scan_clear |=> SCAN_DONE && !SCAN_ACTIVE)
    else $error("Scan did not halt at list end");
  a_scan_wrap: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    state_q == SCAN_RUN && SAMPLE_TICK && remain_q == 7'h00 && last
    && !hardscan_control_q[`HARDSCAN_CONTROL_ONCE] && !scan_clear |=> SCAN_ACTIVE && idx_q == 8'h00)
    else $error("Scan did not wrap to first entry");
endmodule : chassis_slot_select_serial_regs

// ==== testbench/host_link_model.sv ====
/*
  Behavioural acquisition board that writes serial words over the link.
  Assumes one bench process calls send at a time.
*/
`timescale 1ns/10ps
module host_link_model (
  // Serial link
  output logic LINK_SCLK,
  output logic MOSI,
  output logic CONTROLLER_SELECT_N
);
  // ----------------
  // Idle link
  // ----------------
  initial
  begin
    LINK_SCLK = 1'b0;
    MOSI = 1'b0;
    CONTROLLER_SELECT_N = 1'b1;
  end

  // Shifts the first count bits of a width-bit word; clock stands still between frames
  task automatic send(input logic sel_low, input logic [15:0] w, input int width,
                      input int count);
    int i;
    #13;
    CONTROLLER_SELECT_N = ~sel_low;
    for (i = 0; i < count; i++)
    begin
      MOSI = w[width - 1 - i];
      #40 LINK_SCLK = 1'b1;
      #80 LINK_SCLK = 1'b0;
      #40;
    end
    // Released data shows the inverse of the last bit
    CONTROLLER_SELECT_N = 1'b1;
    MOSI = ~MOSI;
    #240;
  endtask : send
endmodule : host_link_model

// ==== testbench/tb_chassis_slot_select_serial_regs.sv ====
/*
  Self-checking bench of the chassis controller serial registers.
  Assumes the package and host_link_model are compiled first.
*/
`timescale 1ns/10ps
module tb_chassis_slot_select_serial_regs;
  // ----------------
  // Signals and reference state
  // ----------------
  logic clk, rst, sclk, mosi, sel_n, single, tick;
  logic [4:0] id;
  logic [15:0] slot_en;
  logic scan_en, trig_en, rewind, scan_rst_n, active, done;
  logic [3:0] scan_slot;
  logic [15:0] sel_sh;
  logic [7:0] ctl_sh;
  logic [10:0] q[$];
  int n_mismatch = 0;
  int checks = 0;
  int cycles = 0;
  int seed = 71722;
  int st, idx, rem, i;

  chassis_slot_select_serial_regs i_dut (
    .CLOCK(clk), .SYS_RST(rst), .LINK_SCLK(sclk), .MOSI(mosi),
    .CONTROLLER_SELECT_N(sel_n), .CHASSIS_ID(id), .SINGLE_CHASSIS(single),
    .SAMPLE_TICK(tick), .SLOT_ENABLE(slot_en), .SCAN_CONTROL_ENABLE(scan_en),
    .TRIGGER_CLOCK_ENABLE(trig_en), .SCAN_LIST_REWIND(rewind),
    .SCAN_LOGIC_RESET_N(scan_rst_n), .SCAN_SLOT(scan_slot), .SCAN_ACTIVE(active),
    .SCAN_DONE(done)
  );

  host_link_model i_host (.LINK_SCLK(sclk), .MOSI(mosi), .CONTROLLER_SELECT_N(sel_n));

  // System clock, 40 ns
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // Hang guard
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 40000)
    begin
      n_mismatch = n_mismatch + 1;
      close_out();
    end
  end

  // ----------------
  // Checking and driving tasks
  // ----------------
  task automatic close_out();
    if (n_mismatch == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : close_out

  task automatic cmp_enable(input logic [15:0] e);
    checks++;
    if (slot_en !== e)
    begin
      n_mismatch++;
      $display("ERROR SLOT_ENABLE expected %h seen %h", e, slot_en);
    end
  endtask : cmp_enable

  task automatic cmp_control();
    logic [3:0] e;
    e = {ctl_sh[6], ctl_sh[3], ctl_sh[1], ctl_sh[0]};
    checks++;
    if ({rewind, scan_rst_n, scan_en, trig_en} !== e)
    begin
      n_mismatch++;
      $display("ERROR control outputs expected %h seen %h", e,
               {rewind, scan_rst_n, scan_en, trig_en});
    end
  endtask : cmp_control

  task automatic cmp_scan(input logic [5:0] e);
    checks++;
    if ({active, done} !== e[5:4] || (e[5] && scan_slot !== e[3:0]))
    begin
      n_mismatch++;
      $display("ERROR scan status expected %h seen %h", e, {active, done, scan_slot});
    end
  endtask : cmp_scan

  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask : settle

  function automatic logic hit();
    return single || sel_sh[8:4] == id;
  endfunction : hit

  // Slots 13 and 14 are internal and never enable a module
  function automatic logic [15:0] exp_en();
    if (!hit() || sel_sh[3:0] == 4'hd || sel_sh[3:0] == 4'he)
      return 16'h0000;
    return 16'h0001 << sel_sh[3:0];
  endfunction : exp_en

  task automatic sel_write(input logic [4:0] chs, input logic [3:0] slot);
    logic [15:0] w;
    w = 16'($random(seed));
    w[8:0] = {chs, slot};
    i_host.send(1'b1, w, 16, 16);
    sel_sh = w;
    settle(8);
  endtask : sel_write

  task automatic ctl_write(input logic [7:0] v);
    sel_write(id, 4'hd);
    cmp_enable(exp_en());
    i_host.send(1'b0, {8'h00, v}, 8, 8);
    ctl_sh = v;
    if (!v[3])
    begin
      q.delete();
      st = 0;
    end
    settle(8);
  endtask : ctl_write

  task automatic fifo_write(input logic [10:0] e);
    i_host.send(1'b0, {5'h15, e}, 16, 16);
    if (hit() && sel_sh[3:0] == 4'he && ctl_sh[3] && q.size() < 256)
      q.push_back(e);
  endtask : fifo_write

  // One sample tick, then the reference sequencer steps and is compared
  task automatic tick_check();
    tick = 1'b1;
    settle(1);
    tick = 1'b0;
    if (ctl_sh[3] && st == 0 && q.size() > 0)
    begin
      idx = 0;
      rem = q[0][6:0];
      st = 1;
    end
    else if (ctl_sh[3] && st == 1)
    begin
      if (rem > 0)
        rem--;
      else if (idx + 1 < q.size())
      begin
        idx++;
        rem = q[idx][6:0];
      end
      else if (ctl_sh[4])
        st = 2;
      else
      begin
        idx = 0;
        rem = q[0][6:0];
      end
    end
    settle(2);
    cmp_scan({st == 1, st == 2, (st == 1) ? 4'(q[idx][10:7] + 4'h1) : 4'h0});
  endtask : tick_check

  // ----------------
  // Main sequence
  // ----------------
  initial
  begin
    rst = 1'b1;
    single = 1'b0;
    tick = 1'b0;
    id = 5'($random(seed));
    sel_sh = 16'h0000;
    ctl_sh = 8'h00;
    st = 0;
    idx = 0;
    rem = 0;
    repeat (6) @(posedge clk);
    #2;
    rst = 1'b0;
    settle(4);
    cmp_enable(16'h0000);
    cmp_control();
    for (i = 0; i < 6; i++)
    begin
      sel_write(id, (i == 0) ? 4'hf : 4'({$random(seed)} % 13));
      cmp_enable(exp_en());
    end
    sel_write(id ^ 5'h10, 4'h2);
    cmp_enable(exp_en());
    single = 1'b1;
    settle(4);
    cmp_enable(exp_en());
    single = 1'b0;
    sel_write(id, 4'h6);
    i_host.send(1'b1, 16'h0003, 16, 9);
    settle(8);
    cmp_enable(exp_en());
    for (i = 0; i < 5; i++)
    begin
      ctl_write(8'($random(seed)));
      cmp_control();
    end
    sel_write(id ^ 5'h01, 4'hd);
    i_host.send(1'b0, {8'h00, ~ctl_sh}, 8, 8);
    settle(8);
    cmp_control();
    // Short list that wraps, then halts once the stop bit is set
    ctl_write(8'h08);
    sel_write(id, 4'he);
    for (i = 0; i < 3; i++)
      fifo_write(11'($random(seed)) & 11'h783);
    settle(8);
    repeat (16) tick_check();
    ctl_write(8'h18);
    repeat (14) tick_check();
    ctl_write(8'h10);
    ctl_write(8'h18);
    repeat (3) tick_check();
    // Foreign chassis entry, then one entry past capacity
    sel_write(id ^ 5'h04, 4'he);
    fifo_write(11'h7ff);
    sel_write(id, 4'he);
    for (i = 0; i < 257; i++)
      fifo_write(11'($random(seed)) & 11'h780);
    settle(8);
    repeat (258) tick_check();
    close_out();
  end
endmodule : tb_chassis_slot_select_serial_regs
